// ---- hw/crcb_pkg.sv ----
// package: constants, types and the crc byte function of the crc16 byte engine
// Overview of operation
// - a write to the upper byte register loads bits 15-8 of the shift register and arms the seed sequence.
// - while armed, the next lower byte write loads bits 7-0, completes the seed and shifts nothing.
// - once seeded, every lower byte write is a data byte shifted in msb first, eight bits, unless a later write replaces or drops it while held in a stall.
// - with no byte held, no light stop and room in the result buffer, all eight bits are shifted so the new value is readable in the cycle after the data write.
// - a read of the upper byte register returns bits 15-8 of the shift register.
// - a read of the lower byte register returns bits 7-0 of the shift register.
// - the feedback polynomial is 0x1021, x^16+x^12+x^5+1, on the 16-bit shift register.
// - no zero padding of the message is needed and the result is never complemented.
// - data bytes accumulate and a new result shows after each group of eight shifted bits.
// - an upper byte write at any time restarts the seed sequence for a fresh calculation.
// - in deep stop the block is not functional and it comes back in its reset state.
// - in light stop the block stands by, freezing a calculation in progress until run resumes.
package crcb_pkg;
  localparam int unsigned ADDR_W      = 2;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned CRC_W       = 16;
  localparam int unsigned BUF_DEPTH   = 2;
  localparam logic [1:0]  OFS_UPPER   = 2'h0;
  localparam logic [1:0]  OFS_LOWER   = 2'h1;
  localparam logic [1:0]  OFS_STATUS  = 2'h2;
  localparam int unsigned ST_ARMED    = 0;
  localparam int unsigned ST_PENDING  = 1;
  localparam int unsigned ST_STANDBY  = 2;
  localparam int unsigned ST_RES_FULL = 3;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_RESET   = 16'h0000;
  localparam logic [7:0]  RD_IDLE     = 8'h00;

  typedef enum logic [0:0] {
    CRCB_DATA    = 1'b0,
    CRCB_SEED_LO = 1'b1
  } crcb_seq_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } crcb_bus_t;

  // eight msb-first shifts through the 0x1021 feedback in one step
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    logic        fb;
    c  = crc;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0} ^ ({CRC_W{fb}} & CRC_POLY);
    end
    return c;
  endfunction
endpackage

// ---- hw/crcb_shreg.sv ----
// 16-bit crc shift register with seed loads and byte-wide shifting
`timescale 1ns/1ps
module crcb_shreg (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        load_upper,
  input  wire logic        load_lower,
  input  wire logic        shift_en,
  input  wire logic [7:0]  byte_in,
  output logic      [15:0] crc_out
);
  logic [15:0] crc_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      crc_r <= crcb_pkg::CRC_RESET;
    end else if (load_upper) begin
      crc_r[15:8] <= byte_in;
    end else if (load_lower) begin
      crc_r[7:0] <= byte_in;
    end else if (shift_en) begin
      crc_r <= crcb_pkg::crc_byte(crc_r, byte_in);
    end
  end

  // raw register, never inverted
  assign crc_out = crc_r;

  property p_shift_math;
    @(posedge clock) disable iff (reset)
      (shift_en && !load_upper && !load_lower) |=> crc_r == crcb_pkg::crc_byte($past(crc_r), $past(byte_in));
  endproperty
  a_shift_math: assert property (p_shift_math) else $error("crc byte step wrong");

  property p_hold;
    @(posedge clock) disable iff (reset)
      !(shift_en || load_upper || load_lower) |=> $stable(crc_r);
  endproperty
  a_hold: assert property (p_hold) else $error("crc changed without cause");
endmodule

// ---- hw/crcb_buf.sv ----
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module crcb_buf (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [15:0] in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [15:0] out_data
);
  logic [15:0] mem_r [crcb_pkg::BUF_DEPTH];
  logic        wptr_r;
  logic        rptr_r;
  logic [1:0]  count_r;
  logic        push;
  logic        pop;

  assign in_ready  = (count_r != 2'(crcb_pkg::BUF_DEPTH));
  assign out_valid = (count_r != 2'h0);
  assign out_data  = mem_r[rptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wptr_r  <= 1'b0;
      rptr_r  <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wptr_r <= ~wptr_r;
      end
      if (pop) begin
        rptr_r <= ~rptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  property p_no_overfill;
    @(posedge clock) disable iff (reset)
      count_r <= 2'(crcb_pkg::BUF_DEPTH);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("result buffer overfilled");
endmodule

// ---- hw/crcb_top.sv ----
// crc16 byte engine: register port, seed sequencing, stall handling and result stream
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module crcb_top (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        stop_deep,
  input  wire logic        stop_light,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             res_valid,
  input  wire logic        res_ready,
  output logic      [15:0] res_data,
  output logic             standby
);
  crcb_pkg::crcb_bus_t bus;
  crcb_pkg::crcb_seq_t seq_r;
  logic                local_reset;
  logic                wr_upper;
  logic                wr_lower;
  logic                data_wr;
  logic                load_lower;
  logic                can_step;
  logic                direct_step;
  logic                pend_step;
  logic                shift_en;
  logic [7:0]          shift_byte;
  logic                pend_r;
  logic [7:0]          pend_byte_r;
  logic                standby_r;
  logic [7:0]          rdata_r;
  logic [15:0]         crc;
  logic [15:0]         next_crc;
  logic                buf_in_ready;

  always_comb begin
    bus.wr    = reg_wr;
    bus.rd    = reg_rd;
    bus.addr  = reg_addr;
    bus.wdata = reg_wdata;
  end

  // deep stop acts as a held reset
  assign local_reset = reset || stop_deep;

  assign wr_upper    = bus.wr && (bus.addr == crcb_pkg::OFS_UPPER);
  assign wr_lower    = bus.wr && (bus.addr == crcb_pkg::OFS_LOWER);
  assign load_lower  = wr_lower && (seq_r == crcb_pkg::CRCB_SEED_LO);
  assign data_wr     = wr_lower && (seq_r == crcb_pkg::CRCB_DATA);
  // light stop and a full result buffer both hold the engine
  assign can_step    = buf_in_ready && !stop_light;
  assign direct_step = data_wr && !pend_r && can_step;
  assign pend_step   = pend_r && can_step && !wr_upper;
  assign shift_en    = direct_step || pend_step;
  assign shift_byte  = pend_step ? pend_byte_r : bus.wdata;
  assign next_crc    = crcb_pkg::crc_byte(crc, shift_byte);

  // seed sequencing
  always_ff @(posedge clock) begin
    if (local_reset) begin
      seq_r <= crcb_pkg::CRCB_DATA;
    end else begin
      case (seq_r)
        crcb_pkg::CRCB_DATA: begin
          if (wr_upper) begin
            seq_r <= crcb_pkg::CRCB_SEED_LO;
          end
        end
        crcb_pkg::CRCB_SEED_LO: begin
          if (wr_lower && !wr_upper) begin
            seq_r <= crcb_pkg::CRCB_DATA;
          end
        end
        default: begin
          seq_r <= crcb_pkg::CRCB_DATA;
        end
      endcase
    end
  end

  // byte held while the engine is stalled
  always_ff @(posedge clock) begin
    if (local_reset) begin
      pend_r <= 1'b0;
    end else if (wr_upper) begin
      pend_r <= 1'b0;
    end else if (data_wr && !direct_step) begin
      pend_r <= 1'b1;
    end else if (pend_step) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (local_reset) begin
      pend_byte_r <= crcb_pkg::RD_IDLE;
    end else if (data_wr && !direct_step) begin
      pend_byte_r <= bus.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (local_reset) begin
      standby_r <= 1'b0;
    end else begin
      standby_r <= stop_light;
    end
  end

  assign standby = standby_r;

  crcb_shreg u_shreg (
    .clock      (clock),
    .reset      (local_reset),
    .load_upper (wr_upper),
    .load_lower (load_lower),
    .shift_en   (shift_en),
    .byte_in    (wr_upper || load_lower ? bus.wdata : shift_byte),
    .crc_out    (crc)
  );

  // every finished byte pushes its result, uncomplemented
  crcb_buf u_buf (
    .clock     (clock),
    .reset     (local_reset),
    .in_valid  (shift_en),
    .in_ready  (buf_in_ready),
    .in_data   (next_crc),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  // read data for one cycle after the strobe
  always_ff @(posedge clock) begin
    if (local_reset) begin
      rdata_r <= crcb_pkg::RD_IDLE;
    end else if (bus.rd) begin
      case (bus.addr)
        crcb_pkg::OFS_UPPER: begin
          rdata_r <= crc[15:8];
        end
        crcb_pkg::OFS_LOWER: begin
          rdata_r <= crc[7:0];
        end
        crcb_pkg::OFS_STATUS: begin
          rdata_r                        <= crcb_pkg::RD_IDLE;
          rdata_r[crcb_pkg::ST_ARMED]    <= (seq_r == crcb_pkg::CRCB_SEED_LO);
          rdata_r[crcb_pkg::ST_PENDING]  <= pend_r;
          rdata_r[crcb_pkg::ST_STANDBY]  <= standby_r;
          rdata_r[crcb_pkg::ST_RES_FULL] <= !buf_in_ready;
        end
        default: begin
          rdata_r <= crcb_pkg::RD_IDLE;
        end
      endcase
    end else begin
      rdata_r <= crcb_pkg::RD_IDLE;
    end
  end

  assign reg_rdata = rdata_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (local_reset);

  sequence s_seed_high;
    wr_upper;
  endsequence

  sequence s_seed_low;
    wr_lower && !wr_upper && (seq_r == crcb_pkg::CRCB_SEED_LO);
  endsequence

  sequence s_data_now;
    wr_lower && (seq_r == crcb_pkg::CRCB_DATA) && !pend_r && buf_in_ready && !stop_light;
  endsequence

  property p_seed_high;
    s_seed_high |=> (crc[15:8] == $past(reg_wdata)) && (seq_r == crcb_pkg::CRCB_SEED_LO) && !pend_r;
  endproperty
  a_seed_high: assert property (p_seed_high) else $error("seed high byte not loaded");

  property p_seed_low;
    s_seed_low |=> (crc[7:0] == $past(reg_wdata)) && $stable(crc[15:8]) && (seq_r == crcb_pkg::CRCB_DATA);
  endproperty
  a_seed_low: assert property (p_seed_low) else $error("seed low byte not loaded");

  property p_seed_then_data;
    s_seed_high ##1 s_seed_low ##1 s_data_now |=> crc == crcb_pkg::crc_byte($past(crc), $past(reg_wdata));
  endproperty
  a_seed_then_data: assert property (p_seed_then_data) else $error("first data byte not shifted");

  property p_next_cycle;
    s_data_now |=> (crc == crcb_pkg::crc_byte($past(crc), $past(reg_wdata))) && !pend_r;
  endproperty
  a_next_cycle: assert property (p_next_cycle) else $error("result not ready next cycle");

  property p_read_upper;
    (reg_rd && reg_addr == crcb_pkg::OFS_UPPER) |=> reg_rdata == $past(crc[15:8]);
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read mismatch");

  property p_read_lower;
    (reg_rd && reg_addr == crcb_pkg::OFS_LOWER) |=> reg_rdata == $past(crc[7:0]);
  endproperty
  a_read_lower: assert property (p_read_lower) else $error("lower read mismatch");

  property p_result_raw;
    (shift_en && res_valid == 1'b0) |=> res_valid && (res_data == crc);
  endproperty
  a_result_raw: assert property (p_result_raw) else $error("pushed result differs from register");

  property p_pending_drains;
    (pend_r && buf_in_ready && !stop_light && !wr_upper && !wr_lower) |=>
      !pend_r && res_valid && (crc == crcb_pkg::crc_byte($past(crc), $past(pend_byte_r)));
  endproperty
  a_pending_drains: assert property (p_pending_drains) else $error("held byte not processed");

  property p_restart;
    (seq_r == crcb_pkg::CRCB_DATA && wr_upper) ##1 wr_upper |=> seq_r == crcb_pkg::CRCB_SEED_LO;
  endproperty
  a_restart: assert property (p_restart) else $error("seed restart lost");

  property p_freeze;
    (stop_light && !wr_upper && !wr_lower) |=> $stable(crc) && $stable(pend_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("calculation moved in standby");

  property p_deep_recover;
    @(posedge clock) disable iff (reset)
      stop_deep |=> (crc == crcb_pkg::CRC_RESET) && (seq_r == crcb_pkg::CRCB_DATA) && !res_valid;
  endproperty
  a_deep_recover: assert property (p_deep_recover) else $error("deep stop did not reset");

  sequence s_stalled;
    wr_lower && (seq_r == crcb_pkg::CRCB_DATA) && !can_step;
  endsequence

  property p_stall_hold;
    s_stalled |=> pend_r && (pend_byte_r == $past(reg_wdata)) && $stable(crc);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stalled data byte not held");

  property p_standby_follow;
    1'b1 |=> standby == $past(stop_light);
  endproperty
  a_standby_follow: assert property (p_standby_follow) else $error("standby does not follow light stop");

  property p_status_read;
    (reg_rd && reg_addr == crcb_pkg::OFS_STATUS) |=>
      reg_rdata == {4'h0, !$past(buf_in_ready), $past(standby_r), $past(pend_r),
                    $past(seq_r == crcb_pkg::CRCB_SEED_LO)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  property p_seed_low_quiet;
    s_seed_low |-> !shift_en;
  endproperty
  a_seed_low_quiet: assert property (p_seed_low_quiet) else $error("seed low byte was shifted");

  property p_seed_high_quiet;
    s_seed_high |-> !shift_en;
  endproperty
  a_seed_high_quiet: assert property (p_seed_high_quiet) else $error("shift beside a seed restart");

  property p_seed_high_keeps_low;
    s_seed_high |=> crc[7:0] == $past(crc[7:0]);
  endproperty
  a_seed_high_keeps_low: assert property (p_seed_high_keeps_low) else $error("seed high write moved low byte");

  property p_push_shows;
    shift_en |=> res_valid;
  endproperty
  a_push_shows: assert property (p_push_shows) else $error("finished byte not offered");

  property p_result_stands;
    (res_valid && !res_ready) |=> res_valid && $stable(res_data);
  endproperty
  a_result_stands: assert property (p_result_stands) else $error("result word moved before taken");

  property p_full_holds;
    (!buf_in_ready && !wr_upper && !wr_lower) |=> $stable(crc);
  endproperty
  a_full_holds: assert property (p_full_holds) else $error("crc moved while result buffer full");

  property p_reset_state;
    @(posedge clock) disable iff (stop_deep)
      reset |=> (crc == crcb_pkg::CRC_RESET) && (seq_r == crcb_pkg::CRCB_DATA) && !pend_r &&
                !res_valid && !standby;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_foreign_write;
    (reg_wr && reg_addr[1] && !pend_r) |=> $stable(crc) && $stable(seq_r);
  endproperty
  a_foreign_write: assert property (p_foreign_write) else $error("write to a non crc offset changed state");

  property p_read_quiet;
    (reg_rd && !reg_wr && !pend_r) |=> $stable(crc) && $stable(seq_r);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read changed the calculation");

  property p_rdata_idle;
    !reg_rd |=> reg_rdata == crcb_pkg::RD_IDLE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its answer cycle");
endmodule

// ---- verification/crcb_top_tb.sv ----
// self-checking testbench for the crc16 byte engine
`timescale 1ns/1ps
module crcb_top_tb;
  logic        clock;
  logic        reset;
  logic        stop_deep;
  logic        stop_light;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        res_valid;
  logic        res_ready;
  logic [15:0] res_data;
  logic        standby;
  int          mismatches;
  int          check_count;
  logic [15:0] v;
  logic [15:0] e;
  logic [15:0] q[$];

  crcb_top uut (
    .clock      (clock),
    .reset      (reset),
    .stop_deep  (stop_deep),
    .stop_light (stop_light),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .res_valid  (res_valid),
    .res_ready  (res_ready),
    .res_data   (res_data),
    .standby    (standby)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // bit-serial reference, msb first
  function automatic logic [15:0] ref_crc(input logic [15:0] c, input logic [7:0] d);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask

  task automatic idle();
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rd_crc(output logic [15:0] c);
    logic [7:0] h;
    logic [7:0] l;
    rd(2'h0, h);
    rd(2'h1, l);
    c = {h, l};
  endtask

  task automatic chk_reg(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check({8'h00, exp}, {8'h00, d});
  endtask

  task automatic seed(input logic [15:0] s);
    wr(2'h0, s[15:8]);
    wr(2'h1, s[7:0]);
  endtask

  // waits for a result word, compares it, then takes it
  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (res_valid !== 1'b1) begin
      if (n == 50) begin
        mismatches++;
        close_out();
      end
      @(posedge clock);
      #1;
      n++;
    end
    check(exp, res_data);
    @(posedge clock);
    res_ready <= 1'b1;
    @(posedge clock);
    res_ready <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    close_out();
  end

  initial begin
    reset      = 1'b1;
    stop_deep  = 1'b0;
    stop_light = 1'b0;
    reg_addr   = 2'h0;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    res_ready  = 1'b1;
    mismatches = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rd_crc(v);
    check(16'h0000, v);
    chk_reg(2'h2, 8'h00);
    chk_reg(2'h3, 8'h00);
    wr(2'h1, 8'h41);
    wr(2'h2, 8'hFF);
    rd_crc(v);
    check(16'h58E5, v);
    wr(2'h0, 8'hA5);
    chk_reg(2'h0, 8'hA5);
    chk_reg(2'h2, 8'h01);
    wr(2'h1, 8'h3C);
    rd_crc(v);
    check(16'hA53C, v);
    chk_reg(2'h2, 8'h00);
    for (int s = 0; s < 2; s++) begin
      e = (s == 1) ? 16'hFFFF : 16'h0000;
      seed(e);
      for (int i = 0; i < 9; i++) begin
        wr(2'h1, 8'(8'h31 + i));
        e = ref_crc(e, 8'(8'h31 + i));
        rd_crc(v);
        check(e, v);
      end
      check((s == 1) ? 16'h29B1 : 16'h31C3, v);
    end
    seed(16'hFFFF);
    repeat (256) wr(2'h1, 8'h41);
    rd_crc(v);
    check(16'hEA0B, v);
    seed(16'h1234);
    wr(2'h1, 8'h55);
    wr(2'h0, 8'hFF);
    wr(2'h0, 8'hFF);
    chk_reg(2'h0, 8'hFF);
    wr(2'h1, 8'hFF);
    wr(2'h1, 8'h41);
    rd_crc(v);
    check(16'hB915, v);
    repeat (3) idle();
    res_ready <= 1'b0;
    seed(16'h0000);
    e = 16'h0000;
    for (int i = 1; i < 4; i++) begin
      wr(2'h1, 8'(i));
      e = ref_crc(e, 8'(i));
      q.push_back(e);
    end
    chk_reg(2'h2, 8'h0A);
    rd_crc(v);
    check(q[1], v);
    while (q.size() > 0) pop(q.pop_front());
    rd_crc(v);
    check(e, v);
    idle();
    res_ready <= 1'b1;
    stop_light <= 1'b1;
    idle();
    idle();
    check(16'h0001, {15'h0000, standby});
    wr(2'h1, 8'h41);
    chk_reg(2'h2, 8'h06);
    rd_crc(v);
    check(e, v);
    e = ref_crc(e, 8'h41);
    idle();
    stop_light <= 1'b0;
    repeat (3) idle();
    rd_crc(v);
    check(e, v);
    idle();
    stop_deep <= 1'b1;
    idle();
    idle();
    stop_deep <= 1'b0;
    idle();
    rd_crc(v);
    check(16'h0000, v);
    wr(2'h1, 8'h41);
    rd_crc(v);
    check(16'h58E5, v);
    close_out();
  end
endmodule
